// file: src/sdcr_map.vh
// register offsets, field positions and reset values for the sdcr block
// assumes a wishbone slave decoding word addresses as byte address div 4
`ifndef SDCR_MAP_VH
`define SDCR_MAP_VH
`define SDCR_IDX_DATA     12'hF60
`define SDCR_IDX_CTRL     12'hF61
`define SDCR_IDX_STAT     12'hF62
`define SDCR_IDX_MODE     12'hF63
`define SDCR_IDX_DIVH     12'hF66
`define SDCR_IDX_DIVL     12'hF67
`define SDCR_CTRL_RST     8'h00
`define SDCR_STAT_RST     8'h01
`define SDCR_MODE_RST     8'h00
`define SDCR_DATA_RST     8'h00
`define SDCR_DIV_RST      16'h0000
`define SDCR_C_INT_GATE   7
`define SDCR_C_FORCE      6
`define SDCR_C_TIMER      5
`define SDCR_C_PHASE      4
`define SDCR_C_POL        3
`define SDCR_C_WOR        2
`define SDCR_C_ROLE       1
`define SDCR_C_EN         0
`define SDCR_S_IRQ        7
`define SDCR_S_COLL       6
`define SDCR_S_ABT        4
`define SDCR_S_TXST       1
`define SDCR_S_SLAS       0
`define SDCR_M_NB_HI      4
`define SDCR_M_NB_LO      2
`endif

// file: src/sdcr_spi.v
// spi data path, control and status registers with a wishbone classic slave
// assumes a 100 MHz clk_i; link pins are asynchronous and synchronised here
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ns
`include "sdcr_map.vh"

module sdcr_spi
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [13:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	output reg         irq_o,
	input  wire        sck_i,
	output reg         sck_o,
	output reg         sck_oe_o,
	input  wire        ss_n_i,
	output reg         ss_n_o,
	output reg         ss_n_oe_o,
	input  wire        miso_i,
	output reg         miso_o,
	output reg         miso_oe_o,
	input  wire        mosi_i,
	output reg         mosi_o,
	output reg         mosi_oe_o
);

	localparam ST_IDLE = 3'b001;
	localparam ST_LEAD = 3'b010;
	localparam ST_TRAIL = 3'b100;

	reg  [7:0]  shift_data_reg;
	reg  [7:0]  serial_ctrl_reg;
	reg         irq_flag;
	reg         write_collision_flag;
	reg         abort_flag;
	reg  [7:0]  mode_reg;
	reg  [15:0] rate_divider;
	reg  [15:0] div_cnt;
	reg  [2:0]  state;
	reg  [3:0]  bits_left;
	reg         sck_int;
	reg         timer_irq;
	reg  [2:0]  sck_s;
	reg  [2:0]  ss_s;
	reg  [1:0]  miso_s;
	reg  [1:0]  mosi_s;
	reg         sl_busy;
	reg         tx_bit;

	wire        int_request_gate     = serial_ctrl_reg[`SDCR_C_INT_GATE];
	wire        forced_request_bit   = serial_ctrl_reg[`SDCR_C_FORCE];
	wire        divider_timer_int_on = serial_ctrl_reg[`SDCR_C_TIMER];
	wire        phase_sel            = serial_ctrl_reg[`SDCR_C_PHASE];
	wire        idle_level_select    = serial_ctrl_reg[`SDCR_C_POL];
	wire        wired_or             = serial_ctrl_reg[`SDCR_C_WOR];
	wire        controller_role_select = serial_ctrl_reg[`SDCR_C_ROLE];
	wire        unit_on              = serial_ctrl_reg[`SDCR_C_EN];
	wire [2:0]  char_length_field    = mode_reg[`SDCR_M_NB_HI:`SDCR_M_NB_LO];

	wire        req     = cyc_i & stb_i & ~ack_o;
	wire        wr      = req & we_i & sel_i[0];
	wire [11:0] idx     = adr_i[13:2];
	wire        busy    = (state != ST_IDLE) | sl_busy;
	wire        m_mode  = unit_on & controller_role_select;
	wire        s_mode  = unit_on & ~controller_role_select;
	wire [3:0]  nbits   = (char_length_field == 3'h0) ? 4'h8 : {1'b0, char_length_field};
	wire        tx_fall = phase_sel ~^ idle_level_select;

	// link edges, read only after the second flop
	wire        sck_rise = sck_s[1] & ~sck_s[2];
	wire        sck_fall = ~sck_s[1] & sck_s[2];
	wire        ss_act   = ~ss_s[1];
	wire        s_smp    = tx_fall ? sck_rise : sck_fall;
	wire        s_tx     = tx_fall ? sck_fall : sck_rise;
	wire        div_tick = (div_cnt == 16'h0001) | (div_cnt == 16'h0000 && rate_divider == 16'h0001);
	wire        done_m   = (state == ST_TRAIL) & div_tick & (bits_left == 4'h1);
	wire        done_s   = s_mode & ss_act & s_smp & (bits_left == 4'h1);
	wire        abort_s  = s_mode & sl_busy & ~ss_act;

	function is_reg;
		input [11:0] a;
		input [11:0] r;
		begin
			is_reg = (a == r);
		end
	endfunction

	always @(posedge clk_i)
	begin
		sck_s  <= {sck_s[1:0], sck_i};
		ss_s   <= {ss_s[1:0], ss_n_i};
		miso_s <= {miso_s[0], miso_i};
		mosi_s <= {mosi_s[0], mosi_i};
	end

	// bus slave: single cycle answer, unmapped reads give zero
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= req;
			dat_o <= 32'h00000000;
			if (req & ~we_i)
			begin
				if (is_reg(idx, `SDCR_IDX_DATA))
					dat_o[7:0] <= shift_data_reg;
				else if (is_reg(idx, `SDCR_IDX_CTRL))
					dat_o[7:0] <= serial_ctrl_reg;
				else if (is_reg(idx, `SDCR_IDX_STAT))
					dat_o[7:0] <= {irq_flag, write_collision_flag, 1'b0, abort_flag, 2'b00,
						busy, ss_s[1]};
				else if (is_reg(idx, `SDCR_IDX_MODE))
					dat_o[7:0] <= mode_reg;
				else if (is_reg(idx, `SDCR_IDX_DIVH))
					dat_o[7:0] <= rate_divider[15:8];
				else if (is_reg(idx, `SDCR_IDX_DIVL))
					dat_o[7:0] <= rate_divider[7:0];
			end
		end
	end

	// config registers and flags; a hardware set wins over a same-cycle clear
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			serial_ctrl_reg      <= `SDCR_CTRL_RST;
			mode_reg             <= `SDCR_MODE_RST;
			rate_divider         <= `SDCR_DIV_RST;
			irq_flag             <= 1'b0;
			write_collision_flag <= 1'b0;
			abort_flag           <= 1'b0;
		end
		else
		begin
			if (wr & is_reg(idx, `SDCR_IDX_CTRL))
				serial_ctrl_reg <= {dat_i[7], dat_i[6] | forced_request_bit, dat_i[5:0]};
			if (wr & is_reg(idx, `SDCR_IDX_MODE))
				mode_reg <= {2'b00, dat_i[5:0]};
			if (wr & is_reg(idx, `SDCR_IDX_DIVH))
				rate_divider[15:8] <= dat_i[7:0];
			if (wr & is_reg(idx, `SDCR_IDX_DIVL))
				rate_divider[7:0] <= dat_i[7:0];
			if (wr & is_reg(idx, `SDCR_IDX_STAT))
			begin
				if (dat_i[`SDCR_S_IRQ])
				begin
					irq_flag <= 1'b0;
					serial_ctrl_reg[`SDCR_C_FORCE] <= 1'b0;
				end
				if (dat_i[`SDCR_S_COLL])
					write_collision_flag <= 1'b0;
				if (dat_i[`SDCR_S_ABT])
					abort_flag <= 1'b0;
			end
			if (wr & is_reg(idx, `SDCR_IDX_DATA) & busy)
				write_collision_flag <= 1'b1;
			if (wr & is_reg(idx, `SDCR_IDX_CTRL) & dat_i[`SDCR_C_FORCE])
				irq_flag <= 1'b1;
			if (done_m | done_s | abort_s)
				irq_flag <= 1'b1;
			if (abort_s)
				abort_flag <= 1'b1;
			// status reverts while disabled
			if (~unit_on)
			begin
				irq_flag             <= 1'b0;
				write_collision_flag <= 1'b0;
				abort_flag           <= 1'b0;
			end
		end
	end

	// master clock divider doubles as the timer while disabled
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_cnt   <= 16'h0000;
			timer_irq <= 1'b0;
		end
		else
		begin
			timer_irq <= 1'b0;
			if ((state == ST_IDLE) & ~(~unit_on & divider_timer_int_on))
				div_cnt <= rate_divider;
			else if (div_tick)
			begin
				div_cnt   <= rate_divider;
				timer_irq <= ~unit_on;
			end
			else
				div_cnt <= div_cnt - 16'h0001;
		end
	end

	// shift engine; master miso is synchronised, so a divider of 1 to 3 samples stale bits
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			shift_data_reg <= `SDCR_DATA_RST;
			state          <= ST_IDLE;
			bits_left      <= 4'h0;
			sck_int        <= 1'b0;
			sl_busy        <= 1'b0;
			tx_bit         <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					sck_int <= idle_level_select;
					if (wr & is_reg(idx, `SDCR_IDX_DATA) & ~busy)
					begin
						shift_data_reg <= dat_i[7:0];
						bits_left      <= nbits;
						tx_bit         <= dat_i[7];
						if (m_mode)
							state <= ST_LEAD;
					end
				end
				ST_LEAD:
					if (div_tick)
					begin
						sck_int <= ~sck_int;
						state   <= ST_TRAIL;
						if (~phase_sel)
							shift_data_reg <= {shift_data_reg[6:0], miso_s[1]};
						else
							tx_bit <= shift_data_reg[7];
					end
				ST_TRAIL:
					if (div_tick)
					begin
						sck_int <= ~sck_int;
						if (phase_sel)
							shift_data_reg <= {shift_data_reg[6:0], miso_s[1]};
						else
							tx_bit <= shift_data_reg[7];
						bits_left <= bits_left - 4'h1;
						state     <= (bits_left == 4'h1) ? ST_IDLE : ST_LEAD;
					end
				default:
					state <= ST_IDLE;
			endcase
			if (~m_mode)
				state <= ST_IDLE;
			if (s_mode)
			begin
				if (~ss_act)
				begin
					sl_busy <= 1'b0;
					if (~sl_busy & ~(wr & is_reg(idx, `SDCR_IDX_DATA)))
						bits_left <= nbits;
				end
				else if (s_smp)
				begin
					sl_busy        <= (bits_left != 4'h1);
					shift_data_reg <= {shift_data_reg[6:0], mosi_s[1]};
					bits_left      <= (bits_left == 4'h1) ? nbits : bits_left - 4'h1;
				end
				else if (s_tx & phase_sel) // phase 1 leading edge starts a character
					sl_busy <= 1'b1;
			end
			else
				sl_busy <= 1'b0;
		end
	end

	// pins; open-drain only pulls low
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o     <= 1'b0;
			sck_o     <= 1'b0;
			sck_oe_o  <= 1'b0;
			ss_n_o    <= 1'b1;
			ss_n_oe_o <= 1'b0;
			miso_o    <= 1'b0;
			miso_oe_o <= 1'b0;
			mosi_o    <= 1'b0;
			mosi_oe_o <= 1'b0;
		end
		else
		begin
			irq_o     <= int_request_gate & (irq_flag | timer_irq);
			sck_o     <= wired_or ? 1'b0 : sck_int;
			sck_oe_o  <= m_mode & (~wired_or | ~sck_int);
			ss_n_o    <= wired_or ? 1'b0 : busy ? 1'b0 : 1'b1;
			ss_n_oe_o <= m_mode & (~wired_or | busy);
			mosi_o    <= wired_or ? 1'b0 : tx_bit;
			mosi_oe_o <= m_mode & (~wired_or | ~tx_bit);
			miso_o    <= wired_or ? 1'b0 : shift_data_reg[7];
			miso_oe_o <= s_mode & ss_act & (~wired_or | ~shift_data_reg[7]);
		end
	end

endmodule

// file: verif/sdcr_checker.sv
// bus and link assertions for sdcr_spi
// assumes classic wishbone and one clock
`timescale 1ns/1ns
module sdcr_checker
(
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [13:0] adr_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        irq_o,
	input wire        sck_o,
	input wire        sck_oe_o,
	input wire        ss_n_o
);
	reg [7:0] ctl;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ctrl shadow lags the slave a cycle, hence the $past slack
	always @(posedge clk_i)
		if (rst_i)
			ctl <= 8'h00;
		else if (cyc_i && stb_i && we_i && ack_o && adr_i[13:2] == 12'hF61)
			ctl <= dat_i[7:0];
	ack_once_a: assert property (ack_o |=> !ack_o)
		else $error("ack held");
	ack_prompt_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	read_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("upper data");
	reset_quiet_a: assert property (disable iff (1'h0)
		rst_i |=> !ack_o && !irq_o && ss_n_o && !sck_oe_o) else $error("reset state");
	irq_gate_a: assert property (irq_o |-> ctl[7])
		else $error("irq ungated");
	role_sck_a: assert property (sck_oe_o |-> ctl[1] || $past(ctl[1]))
		else $error("slave drives sck");
	off_quiet_a: assert property (!ctl[0] && !$past(ctl[0]) |-> !sck_oe_o)
		else $error("off but driving");
	idle_level_a: assert property (sck_oe_o && ss_n_o && $stable(ctl) |-> sck_o == ctl[3])
		else $error("sck idle level");
	cover property (irq_o);
	cover property ($fell(ss_n_o));
	cover property (ack_o && we_i && adr_i[13:2] == 12'hF60);
endmodule
bind sdcr_spi sdcr_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
	.sck_o(sck_o), .sck_oe_o(sck_oe_o), .ss_n_o(ss_n_o));

// file: verif/sdcr_slave_model.sv
// slave device on the far side of the link
// assumes mode 0: sample on rise, shift on fall
`timescale 1ns/1ns
module sdcr_slave_model
(
	input  wire       sck_i,
	input  wire       ss_n_i,
	input  wire       mosi_i,
	input  wire [7:0] tx_i,
	output wire       miso_o,
	output reg  [7:0] rx_o = 8'h00
);
	reg [7:0] sh = 8'h00;
	reg       last = 1'h0;
	always @(negedge ss_n_i)
		sh = tx_i;
	always @(posedge sck_i)
		if (!ss_n_i)
			rx_o <= {rx_o[6:0], mosi_i};
	always @(negedge sck_i)
		if (!ss_n_i)
		begin
			last <= sh[7];
			sh <= {sh[6:0], 1'h0};
		end
	// deselected: inverse of last bit, never a stale copy
	assign miso_o = ss_n_i ? ~last : sh[7];
endmodule

// file: verif/tb_sdcr_spi.sv
// bench for sdcr_spi over wishbone with a slave model
// assumes a taken request acks within 50 cycles
`timescale 1ns/1ns
module tb_sdcr_spi;
	reg         clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	reg  [13:0] adr_i = 14'h0000;
	reg  [31:0] dat_i = 32'h00000000;
	reg         b_sck = 1'h0, b_ss_n = 1'h1, b_mosi = 1'h0;
	reg  [7:0]  rq, got;
	wire [31:0] dat_o;
	wire        ack_o, irq_o, sck_o, sck_oe, ss_n_q, ss_oe, miso_o, miso_oe, mosi_o, mosi_oe;
	wire        m_miso;
	wire [7:0]  m_rx;
	wire        sck_w = sck_oe ? sck_o : b_sck;
	wire        ss_n_w = ss_oe ? ss_n_q : b_ss_n;
	wire        mosi_w = mosi_oe ? mosi_o : b_mosi;
	wire        miso_w = miso_oe ? miso_o : m_miso;
	integer     n_fail = 0, samples_checked = 0, i, n;
	always #5 clk_i = ~clk_i;
	sdcr_spi dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .ss_n_i(ss_n_w), .ss_n_o(ss_n_q),
		.ss_n_oe_o(ss_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe),
		.mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe));
	sdcr_slave_model peer_u (.sck_i(sck_w), .ss_n_i(ss_n_w), .mosi_i(mosi_w), .tx_i(8'h3C),
		.miso_o(m_miso), .rx_o(m_rx));
	task chk(input string s, input [7:0] e, input [7:0] g);
		samples_checked = samples_checked + 1;
		if (g !== e)
			n_fail = n_fail + 1;
		if (g !== e)
			$display("wrong value %0s exp %h got %h", s, e, g);
	endtask
	task wb(input [11:0] a, input w, input [7:0] d);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= {a, 2'h0};
		dat_i <= {24'h000000, d};
		n = 0;
		@(posedge clk_i);
		while (ack_o !== 1'h1 && n < 50)
		begin
			n = n + 1;
			@(posedge clk_i);
		end
		if (n == 50)
			n_fail = n_fail + 1;
		rq = dat_o[7:0];
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task idle_wait;
		for (i = 0; i < 100 && (i == 0 || rq[1]); i = i + 1)
			wb(12'hF62, 1'h0, 8'h00);
		if (rq[1])
			n_fail = n_fail + 1;
	endtask
	// odd split of 125 ns keeps link edges off the clk edges
	task frame(input [7:0] t);
		b_ss_n <= 1'h0;
		#203;
		for (i = 7; i >= 0; i = i - 1)
		begin
			b_mosi = t[i];
			#61 b_sck = 1'h1;
			got[i] = miso_w;
			#64 b_sck = 1'h0;
		end
		#200 b_ss_n = 1'h1;
		@(posedge clk_i);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		n_fail = n_fail + 1;
		conclude;
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(12'hF61, 1'h0, 8'h00);
		chk("ctrl", 8'h00, rq);
		wb(12'hF65, 1'h0, 8'h00);
		chk("unmapped", 8'h00, rq);
		$display("test reset done");
		wb(12'hF67, 1'h1, 8'h04);
		wb(12'hF61, 1'h1, 8'h03);
		wb(12'hF60, 1'h1, 8'hA5);
		wb(12'hF60, 1'h1, 8'hFF);
		wb(12'hF62, 1'h0, 8'h00);
		chk("ovr busy", 8'h42, rq & 8'h42);
		idle_wait;
		chk("m out", 8'hA5, m_rx);
		chk("irq gate", 8'h00, {7'h00, irq_o});
		wb(12'hF60, 1'h0, 8'h00);
		chk("m in", 8'h3C, rq);
		wb(12'hF62, 1'h1, 8'hC0);
		wb(12'hF62, 1'h0, 8'h00);
		chk("ovr clr", 8'h00, rq & 8'hC0);
		$display("test master done");
		wb(12'hF63, 1'h1, 8'h10);
		wb(12'hF60, 1'h1, 8'hA0);
		idle_wait;
		chk("short out", 8'h5A, m_rx);
		wb(12'hF60, 1'h0, 8'h00);
		chk("short in", 8'h03, rq);
		$display("test short done");
		wb(12'hF62, 1'h1, 8'h80);
		wb(12'hF61, 1'h1, 8'hC3);
		wb(12'hF62, 1'h0, 8'h00);
		chk("irq flag", 8'h80, rq & 8'h80);
		chk("irq pin", 8'h01, {7'h00, irq_o});
		wb(12'hF62, 1'h1, 8'h80);
		wb(12'hF61, 1'h0, 8'h00);
		chk("str", 8'h83, rq);
		$display("test forced done");
		wb(12'hF61, 1'h1, 8'h01);
		wb(12'hF63, 1'h1, 8'h00);
		wb(12'hF60, 1'h1, 8'h96);
		frame(8'h5A);
		chk("s out", 8'h96, got);
		wb(12'hF60, 1'h0, 8'h00);
		chk("s in", 8'h5A, rq);
		wb(12'hF62, 1'h0, 8'h00);
		chk("s stat", 8'h80, rq & 8'h90);
		$display("test slave done");
		wb(12'hF61, 1'h1, 8'hA0);
		n = 0;
		while (irq_o !== 1'h1 && n < 40)
		begin
			n = n + 1;
			@(posedge clk_i);
		end
		chk("timer irq", 8'h01, {7'h00, irq_o});
		wb(12'hF62, 1'h0, 8'h00);
		chk("timer stat", 8'h00, rq & 8'h80);
		$display("test timer done");
		conclude;
	end
endmodule
